// ===== pkg/priority_interrupt_resolver_pkg.sv
// Constants shared by the interrupt priority resolver.
package priority_interrupt_resolver_pkg;
  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFF_PRIORITY_A = 8'h00;
  localparam logic [7:0] OFF_PRIORITY_B = 8'h04;
  localparam logic [7:0] OFF_PRIORITY_C = 8'h08;
  localparam logic [7:0] OFF_PRIORITY_D = 8'h0C;
  localparam logic [7:0] OFF_PRIORITY_E = 8'h10;
  localparam logic [7:0] OFF_CONTROL_ZERO = 8'h14;
  localparam logic [7:0] OFF_PIN_SENSE = 8'h18;
  localparam logic [7:0] OFF_PIN_FLAGS = 8'h1C;
  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int NMI_EDGE_POLARITY_BIT = 0;
  localparam int PIN_LEVEL_LSB = 8;
  localparam logic [15:0] PRIORITY_RESET = 16'h0000;
  localparam logic [15:0] SENSE_RESET = 16'h0000;
  localparam logic [1:0] SENSE_LOW = 2'h0;
  localparam logic [1:0] SENSE_FALL = 2'h1;
  localparam logic [1:0] SENSE_RISE = 2'h2;
  localparam logic [1:0] SENSE_BOTH = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************************************
  // Sources, levels and vectors
  // ****************************************************************
  localparam int NUM_PINS = 8;
  localparam int NUM_PERIPH = 18;
  localparam int NUM_SRC = 3 + NUM_PINS + NUM_PERIPH;
  localparam int SRC_BREAK = 0;
  localparam int SRC_NMI = 1;
  localparam int SRC_DEBUG = 2;
  localparam int SRC_PIN0 = 3;
  localparam int SRC_PERIPH0 = 11;
  localparam logic [4:0] LEVEL_NMI = 5'h10;
  localparam logic [4:0] LEVEL_FIXED = 5'h0F;
  localparam logic [3:0] MASK_LOAD_MAX = 4'hF;
  localparam logic [7:0] VEC_BREAK = 8'h0C;
  localparam logic [7:0] VEC_NMI = 8'h0B;
  localparam logic [7:0] VEC_DEBUG = 8'h0D;
  localparam logic [7:0] VEC_PIN_LOW_BASE = 8'h40;
  localparam logic [7:0] VEC_PIN_HIGH_BASE = 8'h50;
  localparam logic [7:0] VEC_WATCHDOG = 8'h54;
  localparam int VEC_TABLE_SCALE = 4;
endpackage

// ===== design/priority_interrupt_resolver.sv
// Interrupt priority resolver with AXI4-Lite register slave.
`timescale 1ns/1ns
`default_nettype none
// ******************************************************************
// Overview of operation
// - Five 16-bit read/write priority registers, four 4-bit level fields each.
// - Each field is a binary level, 0000 lowest through 1111 highest.
// - A maskable source at level zero is never forwarded.
// - The non-maskable request has level sixteen and is always accepted.
// - Non-maskable input is edge detected; a control bit picks rising or falling.
// - Accepting the non-maskable request reports mask level fifteen.
// - Each of eight pins selects low, falling, rising or both-edge sensing.
// - Sense code 00 low, 01 falling, 10 rising, 11 both; resets to zero.
// - Pins 0-3 use priority_a, pins 4-7 priority_b, high field first.
// - Low-level mode requests only while the pin is low.
// - Edge modes latch the request until the CPU accepts it.
// - Writing zero after reading one cancels a latched pin request.
// - An accepted pin reports its programmed level as the mask.
// - Peripherals own vectors; levels from priority_c to priority_e.
// - Break request: level fifteen, edge latched, held until accepted.
// - Debug port request: level fifteen, edge latched, held until accepted.
// - Sources sharing one field resolve toward the smaller vector.
// - All programmable levels reset to zero.
// - Equal levels resolve by the fixed default source order.
// - Vectors: break 12, NMI 11, debug 13, pins 64-67 and 80-83, watchdog 84.
// - Peripheral vectors 85 to 101; 88 to 99 share fields of register D, four vectors per field.
// - Forward the winner only when its level exceeds the CPU mask.
// ******************************************************************
module priority_interrupt_resolver (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic nmi_pin,
  input wire logic [7:0] irq_pins,
  input wire logic break_condition_request,
  input wire logic debug_port_request,
  input wire logic [17:0] periph_requests,
  input wire logic [3:0] cpu_mask_level,
  input wire logic cpu_ack,
  input wire logic [7:0] cpu_ack_vector,
  output logic cpu_irq_q,
  output logic [3:0] cpu_irq_level_q,
  output logic [7:0] cpu_irq_vector_q
);
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [3:0] field_of(input logic [15:0] r, input int slot);
    field_of = r[15 - 4 * slot -: 4];
  endfunction
  function automatic logic [7:0] pin_vec(input int i);
    pin_vec = (i < 4) ? 8'(priority_interrupt_resolver_pkg::VEC_PIN_LOW_BASE + i)
                      : 8'(priority_interrupt_resolver_pkg::VEC_PIN_HIGH_BASE + i - 4);
  endfunction
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction
  // ****************************************************************
  // Register bus
  // ****************************************************************
  logic aw_hold_q, w_hold_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [15:0] prio_q [5];
  logic nmi_pol_q;
  logic [15:0] sense_q;
  logic [7:0] pin_flag_q, armed_q;
  logic [7:0] irq_meta_q, irq_sync_q, irq_prev_q;
  logic nmi_meta_q, nmi_sync_q, nmi_prev_q;
  logic brk_prev_q, dbg_prev_q, brk_pend_q, dbg_pend_q, nmi_pend_q;
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire do_write = aw_hold_q & w_hold_q & ~s_axi_bvalid;
  wire aw_hold_d = do_write ? 1'b0 : (aw_hold_q | aw_take);
  wire w_hold_d = do_write ? 1'b0 : (w_hold_q | w_take);
  wire bvalid_d = do_write | (s_axi_bvalid & ~s_axi_bready);
  wire rvalid_d = ar_take | (s_axi_rvalid & ~s_axi_rready);
  wire [7:0] wa = aw_addr_q;
  wire wr_a = do_write && wa == priority_interrupt_resolver_pkg::OFF_PRIORITY_A;
  wire wr_b = do_write && wa == priority_interrupt_resolver_pkg::OFF_PRIORITY_B;
  wire wr_c = do_write && wa == priority_interrupt_resolver_pkg::OFF_PRIORITY_C;
  wire wr_d = do_write && wa == priority_interrupt_resolver_pkg::OFF_PRIORITY_D;
  wire wr_e = do_write && wa == priority_interrupt_resolver_pkg::OFF_PRIORITY_E;
  wire wr_ctl = do_write && wa == priority_interrupt_resolver_pkg::OFF_CONTROL_ZERO;
  wire wr_sense = do_write && wa == priority_interrupt_resolver_pkg::OFF_PIN_SENSE;
  wire wr_flags = do_write && wa == priority_interrupt_resolver_pkg::OFF_PIN_FLAGS;
  wire wr_hit = wr_a | wr_b | wr_c | wr_d | wr_e | wr_ctl | wr_sense | wr_flags;
  wire [15:0] flags_word = {irq_sync_q, pin_flag_q};
  logic [31:0] rd_word;
  logic rd_hit;
  wire [7:0] ra = s_axi_araddr;
  always_comb begin
    rd_hit = 1'b1;
    rd_word = 32'h0000_0000;
    if (ra == priority_interrupt_resolver_pkg::OFF_PRIORITY_A) begin
      rd_word[15:0] = prio_q[0];
    end else if (ra == priority_interrupt_resolver_pkg::OFF_PRIORITY_B) begin
      rd_word[15:0] = prio_q[1];
    end else if (ra == priority_interrupt_resolver_pkg::OFF_PRIORITY_C) begin
      rd_word[15:0] = prio_q[2];
    end else if (ra == priority_interrupt_resolver_pkg::OFF_PRIORITY_D) begin
      rd_word[15:0] = prio_q[3];
    end else if (ra == priority_interrupt_resolver_pkg::OFF_PRIORITY_E) begin
      rd_word[15:0] = prio_q[4];
    end else if (ra == priority_interrupt_resolver_pkg::OFF_CONTROL_ZERO) begin
      rd_word[priority_interrupt_resolver_pkg::NMI_EDGE_POLARITY_BIT] = nmi_pol_q;
    end else if (ra == priority_interrupt_resolver_pkg::OFF_PIN_SENSE) begin
      rd_word[15:0] = sense_q;
    end else if (ra == priority_interrupt_resolver_pkg::OFF_PIN_FLAGS) begin
      rd_word[15:0] = flags_word;
    end else begin
      rd_hit = 1'b0;
    end
  end
  wire rd_flags = ar_take && ra == priority_interrupt_resolver_pkg::OFF_PIN_FLAGS;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= priority_interrupt_resolver_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= priority_interrupt_resolver_pkg::RESP_OKAY;
    end else if (clk_en) begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      if (aw_take) aw_addr_q <= {s_axi_awaddr[7:2], 2'h0};
      if (w_take) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      s_axi_awready <= ~aw_hold_d & ~bvalid_d;
      s_axi_wready <= ~w_hold_d & ~bvalid_d;
      s_axi_bvalid <= bvalid_d;
      if (do_write) begin
        s_axi_bresp <= wr_hit ? priority_interrupt_resolver_pkg::RESP_OKAY
                              : priority_interrupt_resolver_pkg::RESP_SLVERR;
      end
      s_axi_arready <= ~rvalid_d;
      s_axi_rvalid <= rvalid_d;
      if (ar_take) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? priority_interrupt_resolver_pkg::RESP_OKAY
                              : priority_interrupt_resolver_pkg::RESP_SLVERR;
      end
    end
  end
  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      for (int r = 0; r < 5; r++) begin
        prio_q[r] <= priority_interrupt_resolver_pkg::PRIORITY_RESET;
      end
      nmi_pol_q <= 1'b0;
      sense_q <= priority_interrupt_resolver_pkg::SENSE_RESET;
    end else if (clk_en) begin
      if (wr_a) prio_q[0] <= merge16(prio_q[0], w_data_q, w_strb_q);
      if (wr_b) prio_q[1] <= merge16(prio_q[1], w_data_q, w_strb_q);
      if (wr_c) prio_q[2] <= merge16(prio_q[2], w_data_q, w_strb_q);
      if (wr_d) prio_q[3] <= merge16(prio_q[3], w_data_q, w_strb_q);
      if (wr_e) prio_q[4] <= merge16(prio_q[4], w_data_q, w_strb_q);
      if (wr_ctl && w_strb_q[0]) begin
        nmi_pol_q <= w_data_q[priority_interrupt_resolver_pkg::NMI_EDGE_POLARITY_BIT];
      end
      if (wr_sense) sense_q <= merge16(sense_q, w_data_q, w_strb_q);
    end
  end
  // ****************************************************************
  // Request detection
  // ****************************************************************
  wire ack_break = cpu_ack && cpu_ack_vector == priority_interrupt_resolver_pkg::VEC_BREAK;
  wire ack_nmi = cpu_ack && cpu_ack_vector == priority_interrupt_resolver_pkg::VEC_NMI;
  wire ack_debug = cpu_ack && cpu_ack_vector == priority_interrupt_resolver_pkg::VEC_DEBUG;
  wire nmi_edge = nmi_pol_q ? (nmi_sync_q & ~nmi_prev_q) : (~nmi_sync_q & nmi_prev_q);
  wire brk_rise = break_condition_request & ~brk_prev_q;
  wire dbg_rise = debug_port_request & ~dbg_prev_q;
  logic [7:0] pin_set, pin_clr, pin_edge_mode;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      logic [1:0] s;
      s = sense_q[2 * i +: 2];
      pin_edge_mode[i] = s != priority_interrupt_resolver_pkg::SENSE_LOW;
      pin_set[i] = (s == priority_interrupt_resolver_pkg::SENSE_FALL &&
                    !irq_sync_q[i] && irq_prev_q[i]) ||
                   (s == priority_interrupt_resolver_pkg::SENSE_RISE &&
                    irq_sync_q[i] && !irq_prev_q[i]) ||
                   (s == priority_interrupt_resolver_pkg::SENSE_BOTH &&
                    irq_sync_q[i] != irq_prev_q[i]);
      pin_clr[i] = (cpu_ack && cpu_ack_vector == pin_vec(i)) ||
                   (wr_flags && w_strb_q[0] && !w_data_q[i] && armed_q[i]);
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      irq_meta_q <= 8'hFF;
      irq_sync_q <= 8'hFF;
      irq_prev_q <= 8'hFF;
      nmi_meta_q <= 1'b0;
      nmi_sync_q <= 1'b0;
      nmi_prev_q <= 1'b0;
      brk_prev_q <= 1'b0;
      dbg_prev_q <= 1'b0;
      brk_pend_q <= 1'b0;
      dbg_pend_q <= 1'b0;
      nmi_pend_q <= 1'b0;
      pin_flag_q <= 8'h00;
      armed_q <= 8'h00;
    end else if (clk_en) begin
      irq_meta_q <= irq_pins;
      irq_sync_q <= irq_meta_q;
      irq_prev_q <= irq_sync_q;
      nmi_meta_q <= nmi_pin;
      nmi_sync_q <= nmi_meta_q;
      nmi_prev_q <= nmi_sync_q;
      brk_prev_q <= break_condition_request;
      dbg_prev_q <= debug_port_request;
      brk_pend_q <= brk_rise | (brk_pend_q & ~ack_break);
      dbg_pend_q <= dbg_rise | (dbg_pend_q & ~ack_debug);
      nmi_pend_q <= nmi_edge | (nmi_pend_q & ~ack_nmi);
      for (int i = 0; i < 8; i++) begin
        if (!pin_edge_mode[i]) begin
          pin_flag_q[i] <= ~irq_sync_q[i];
        end else begin
          pin_flag_q[i] <= pin_set[i] | (pin_flag_q[i] & ~pin_clr[i]);
        end
      end
      if (do_write && wa == priority_interrupt_resolver_pkg::OFF_PIN_FLAGS) begin
        armed_q <= 8'h00;
      end else if (rd_flags) begin
        armed_q <= armed_q | pin_flag_q;
      end
    end
  end
  // ****************************************************************
  // Priority resolution
  // ****************************************************************
  logic [4:0] lvl [priority_interrupt_resolver_pkg::NUM_SRC];
  logic [7:0] vec [priority_interrupt_resolver_pkg::NUM_SRC];
  logic [priority_interrupt_resolver_pkg::NUM_SRC-1:0] pend;
  always_comb begin
    pend = {periph_requests, pin_flag_q, dbg_pend_q, nmi_pend_q, brk_pend_q};
    lvl[priority_interrupt_resolver_pkg::SRC_BREAK] = priority_interrupt_resolver_pkg::LEVEL_FIXED;
    lvl[priority_interrupt_resolver_pkg::SRC_NMI] = priority_interrupt_resolver_pkg::LEVEL_NMI;
    lvl[priority_interrupt_resolver_pkg::SRC_DEBUG] = priority_interrupt_resolver_pkg::LEVEL_FIXED;
    vec[priority_interrupt_resolver_pkg::SRC_BREAK] = priority_interrupt_resolver_pkg::VEC_BREAK;
    vec[priority_interrupt_resolver_pkg::SRC_NMI] = priority_interrupt_resolver_pkg::VEC_NMI;
    vec[priority_interrupt_resolver_pkg::SRC_DEBUG] = priority_interrupt_resolver_pkg::VEC_DEBUG;
    for (int i = 0; i < 8; i++) begin
      lvl[priority_interrupt_resolver_pkg::SRC_PIN0 + i] =
        {1'b0, field_of(prio_q[i / 4], i % 4)};
      vec[priority_interrupt_resolver_pkg::SRC_PIN0 + i] = pin_vec(i);
    end
    for (int k = 0; k < priority_interrupt_resolver_pkg::NUM_PERIPH; k++) begin
      int reg_i, slot;
      reg_i = (k < 4) ? 2 : (k < 16) ? 3 : 4;
      slot = (k < 4) ? k : (k < 16) ? (k - 4) / 4 : k - 16;
      lvl[priority_interrupt_resolver_pkg::SRC_PERIPH0 + k] =
        {1'b0, field_of(prio_q[reg_i], slot)};
      vec[priority_interrupt_resolver_pkg::SRC_PERIPH0 + k] =
        8'(priority_interrupt_resolver_pkg::VEC_WATCHDOG + k);
    end
  end
  logic [4:0] best_lvl;
  logic [7:0] best_vec;
  always_comb begin
    best_lvl = 5'h00;
    best_vec = 8'h00;
    // A later source replaces the winner only with a strictly higher level.
    for (int n = 0; n < priority_interrupt_resolver_pkg::NUM_SRC; n++) begin
      if (pend[n] && lvl[n] > best_lvl) begin
        best_lvl = lvl[n];
        best_vec = vec[n];
      end
    end
  end
  wire forward = best_lvl > {1'b0, cpu_mask_level};
  wire [3:0] load_lvl = best_lvl[4] ? priority_interrupt_resolver_pkg::MASK_LOAD_MAX
                                    : best_lvl[3:0];
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cpu_irq_q <= 1'b0;
      cpu_irq_level_q <= 4'h0;
      cpu_irq_vector_q <= 8'h00;
    end else if (clk_en) begin
      cpu_irq_q <= forward;
      cpu_irq_level_q <= forward ? load_lvl : 4'h0;
      cpu_irq_vector_q <= forward ? best_vec : 8'h00;
    end
  end
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst || !clk_en);
  property p_prio_reset;
    $rose(nrst) |-> prio_q[0] == 16'h0000 && prio_q[4] == 16'h0000;
  endproperty
  a_prio_reset: assert property (p_prio_reset) else $error("priority not zero after reset");
  property p_no_level_zero;
    cpu_irq_q |-> cpu_irq_level_q != 4'h0;
  endproperty
  a_no_level_zero: assert property (p_no_level_zero) else $error("level zero forwarded");
  property p_nmi_wins;
    nmi_pend_q |=> cpu_irq_q && cpu_irq_vector_q == 8'h0B && cpu_irq_level_q == 4'hF;
  endproperty
  a_nmi_wins: assert property (p_nmi_wins) else $error("pending NMI not forwarded");
  property p_above_mask;
    cpu_irq_q && cpu_irq_vector_q != 8'h0B |-> cpu_irq_level_q > $past(cpu_mask_level);
  endproperty
  a_above_mask: assert property (p_above_mask) else $error("level not above mask");
  property p_low_level_drop;
    sense_q[1:0] == 2'h0 && irq_sync_q[0] |=> !pin_flag_q[0];
  endproperty
  a_low_level_drop: assert property (p_low_level_drop) else $error("level flag kept");
  property p_edge_hold;
    pin_flag_q[0] && pin_edge_mode[0] && !pin_clr[0] && $stable(sense_q) |=> pin_flag_q[0];
  endproperty
  a_edge_hold: assert property (p_edge_hold) else $error("edge flag lost");
  property p_sw_cancel;
    pin_edge_mode[0] && wr_flags && w_strb_q[0] && !w_data_q[0] && armed_q[0] && !pin_set[0]
      |=> !pin_flag_q[0];
  endproperty
  a_sw_cancel: assert property (p_sw_cancel) else $error("cancel ignored");
  property p_break_ack;
    brk_pend_q && ack_break && !brk_rise |=> !brk_pend_q ##1 (!brk_pend_q || $past(brk_rise));
  endproperty
  a_break_ack: assert property (p_break_ack) else $error("break not cleared");
  property p_bresp;
    do_write |=> s_axi_bvalid [*1] ##0 !s_axi_awready;
  endproperty
  a_bresp: assert property (p_bresp) else $error("no write response");
  c_nmi: cover property (nmi_edge ##[1:3] cpu_irq_q && cpu_irq_vector_q == 8'h0B);
  c_pin_edge: cover property (pin_set[3] ##[1:4] cpu_ack && cpu_ack_vector == 8'h43);
  c_cancel: cover property (rd_flags ##[1:20] wr_flags && armed_q != 8'h00);
  c_periph: cover property (cpu_irq_q && cpu_irq_vector_q == 8'h65);
endmodule
`default_nettype wire

// ===== verification/cpu_core_model.sv
// CPU core model that accepts forwarded interrupt requests and acknowledges them.
`timescale 1ns/1ns
`default_nettype none
module cpu_core_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic accept_en,
  input wire logic [3:0] ack_delay,
  input wire logic cpu_irq_q,
  input wire logic [3:0] cpu_irq_level_q,
  input wire logic [7:0] cpu_irq_vector_q,
  output logic cpu_ack,
  output logic [7:0] cpu_ack_vector,
  output logic [7:0] last_vec,
  output logic [3:0] last_lvl,
  output int n_acc
);
  int cnt;
  // The request stays up two edges after an acknowledge, so the wait restarts from zero.
  // The idle vector toggles every cycle so that a stale value is never mistaken for an answer.
  always @(posedge ref_clk) begin
    cpu_ack <= 1'b0;
    cpu_ack_vector <= ~cpu_ack_vector;
    cnt <= cpu_irq_q ? cnt + 1 : 0;
    if (!nrst) begin
      cnt <= 0;
      n_acc <= 0;
      cpu_ack_vector <= 8'h5A;
    end else if (accept_en && cpu_irq_q && cnt >= ack_delay + 3) begin
      cpu_ack <= 1'b1;
      cpu_ack_vector <= cpu_irq_vector_q;
      last_vec <= cpu_irq_vector_q;
      last_lvl <= cpu_irq_level_q;
      n_acc <= n_acc + 1;
      cnt <= 0;
    end
  end
endmodule
`default_nettype wire

// ===== verification/priority_interrupt_resolver_tb_top.sv
// Self-checking bench for the interrupt priority resolver.
`timescale 1ns/1ns
`default_nettype none
module priority_interrupt_resolver_tb_top;
  logic ref_clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, cpu_ack;
  logic nmi, brk, dbg, acc_en, irq, en;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [3:0] mask, lvl, last_lvl, dly;
  logic [7:0] s_axi_awaddr, s_axi_araddr, pins, vec, cpu_ack_vector, last_vec;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
  logic [17:0] periph;
  logic [28:0] pend;
  int pr[5];
  int n_fail, compares, n_acc, n0, k;
  priority_interrupt_resolver u_dut (.ref_clk, .nrst, .clk_en(en), .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'h3), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .nmi_pin(nmi),
    .irq_pins(pins), .break_condition_request(brk), .debug_port_request(dbg),
    .periph_requests(periph), .cpu_mask_level(mask), .cpu_ack, .cpu_ack_vector, .cpu_irq_q(irq),
    .cpu_irq_level_q(lvl), .cpu_irq_vector_q(vec));
  cpu_core_model u_cpu (.ref_clk, .nrst, .accept_en(acc_en), .ack_delay(dly), .cpu_irq_q(irq),
    .cpu_irq_level_q(lvl), .cpu_irq_vector_q(vec), .cpu_ack, .cpu_ack_vector, .last_vec,
    .last_lvl, .n_acc);
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic hang();
    n_fail++;
    end_of_test();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
    if (!s_axi_bvalid) hang();
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'b0;
    rd_q = s_axi_rdata;
    resp = s_axi_rresp;
    if (!s_axi_rvalid) hang();
  endtask
  task automatic flags(input logic [15:0] e);
    rd(priority_interrupt_resolver_pkg::OFF_PIN_FLAGS);
    chk("pin flags", rd_q, {16'h0000, e});
  endtask
  function automatic int slev(int s);
    int g;
    if (s == 1) return 16;
    if (s == 0 || s == 2) return 15;
    g = s < 15 ? s - 3 : s < 27 ? 12 + (s - 15) / 4 : s - 11;
    return (pr[g / 4] >> (12 - 4 * (g % 4))) & 15;
  endfunction
  // Replacing only on a strictly higher level hands every tie to the earlier source.
  task automatic cmp();
    int best, bl, l;
    best = 0;
    bl = 0;
    for (int s = 0; s < 29; s++) begin
      l = slev(s);
      if (pend[s] && l > bl) begin
        best = s;
        bl = l;
      end
    end
    if (bl <= mask) bl = 0;
    chk("irq", irq, bl > 0);
    chk("level", lvl, bl > 15 ? 15 : bl);
    chk("vector", vec, bl == 0 ? 0 : best < 3 ? (best == 1 ? 11 : 12 + best / 2) :
      best < 7 ? 61 + best : 73 + best);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    nrst = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {nmi, brk, dbg, acc_en, mask, dly, periph, pend} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    pins = 8'hFF;
    en = 1'b1;
    void'($urandom(32'h6627));
    cyc(16);
    nrst <= 1'b1;
    cyc(3);
    for (int a = 0; a < 8; a++) begin
      rd(8'(4 * a));
      chk("reset value", rd_q, a == 7 ? 32'h0000FF00 : 32'h0);
    end
    rd(8'h40);
    chk("unmapped read", {resp, rd_q[29:0]}, 32'h80000000);
    wr(8'h40, 32'h1234);
    chk("unmapped write", resp, 2);
    for (int i = 0; i < 5; i++) begin
      pr[i] = $urandom & (i == 4 ? 16'hFF00 : i == 3 ? 16'hFFF0 : 16'hFFFF);
      wr(8'(4 * i), $urandom & 32'hFFFF0000 | pr[i]);
      rd(8'(4 * i));
      chk("priority", {resp, rd_q[29:0]}, pr[i]);
    end
    for (int i = 0; i < 24; i++) begin
      @(posedge ref_clk);
      periph <= 18'($urandom);
      mask <= 4'($urandom % 8);
      cyc(3);
      pend[28:11] = periph;
      cmp();
    end
    periph <= 18'h00000;
    pend = '0;
    for (int i = 0; i < 9; i++) begin
      @(posedge ref_clk);
      pins <= i == 8 ? 8'hFF : 8'($urandom);
      cyc(6);
      pend[10:3] = ~pins;
      cmp();
      flags({pins, ~pins});
    end
    // The level-mode reads above left bits armed; any write to the flags disarms them.
    wr(priority_interrupt_resolver_pkg::OFF_PIN_FLAGS, 32'h0);
    for (int m = 1; m < 4; m++) begin
      wr(priority_interrupt_resolver_pkg::OFF_PIN_SENSE, 32'h5555 * m);
      @(posedge ref_clk);
      pins <= 8'h00;
      cyc(6);
      pend[10:3] = {8{m[0]}};
      cmp();
      @(posedge ref_clk);
      pins <= 8'hFF;
      cyc(6);
      pend[10:3] = 8'hFF;
      wr(priority_interrupt_resolver_pkg::OFF_PIN_FLAGS, 32'h0);
      cmp();
      flags(16'hFFFF);
      wr(priority_interrupt_resolver_pkg::OFF_PIN_FLAGS, 32'h0);
      pend = '0;
      cyc(3);
      flags(16'hFF00);
    end
    wr(priority_interrupt_resolver_pkg::OFF_CONTROL_ZERO, 32'h1);
    @(posedge ref_clk);
    mask <= 4'hF;
    brk <= 1'b1;
    acc_en <= 1'b1;
    cyc(4);
    pend[0] = 1'b1;
    cmp();
    for (int j = 0; j < 4; j++) begin
      if (j == 3) wr(priority_interrupt_resolver_pkg::OFF_CONTROL_ZERO, 32'h0);
      n0 = n_acc;
      k = 0;
      @(posedge ref_clk);
      dly <= 4'(j * 3);
      case (j)
        0: nmi <= 1'b1;
        1: mask <= 4'hE;
        2: dbg <= 1'b1;
        default: nmi <= 1'b0;
      endcase
      while (n_acc == n0 && k < 60) begin
        @(posedge ref_clk);
        k++;
      end
      if (n_acc == n0) hang();
      chk("ack vector", last_vec, j == 1 ? 12 : j == 2 ? 13 : 11);
      chk("ack level", last_lvl, 15);
    end
    cyc(4);
    pend = '0;
    cmp();
    // With the enable low every flop holds, so raised requests must not reach the core yet.
    @(posedge ref_clk);
    en <= 1'b0;
    mask <= 4'h0;
    periph <= 18'h3FFFF;
    cyc(4);
    chk("frozen irq", irq, 0);
    en <= 1'b1;
    cyc(4);
    pend[28:11] = periph;
    cmp();
    end_of_test();
  end
endmodule
`default_nettype wire
